/* hdl/eeprom_host.sv */
// host controller driving a byte-wide parallel eeprom through its pins
`timescale 1ns/10ps
module eeprom_host
    import eeprom_host_pkg::*;
#(
    parameter int INHIBIT_CYC = POWER_UP_WRITE_INHIBIT_CYC,
    parameter int READ_DELAY_CYC = POWER_UP_READ_DELAY_CYC,
    parameter int LOAD_WAIT_CYC = BYTE_LOAD_INTERVAL_CYC
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    // user side
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_last_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_data_i,
    output logic ready_o,
    output logic rd_valid_o,
    output logic [DATA_W-1:0] rd_data_o,
    output logic busy_o,
    // eeprom pins
    output logic [ADDR_W-1:0] byte_address_o,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_n_o,
    input wire logic [DATA_W-1:0] dq_i,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o
);
    typedef enum {
        ST_POWERUP, ST_IDLE, ST_RD, ST_WR_LOW, ST_WR_GAP, ST_LOAD_WAIT,
        ST_POLL, ST_POLL_GAP
    } state_t;

    // refuse counts the 24-bit wait counter or the page load reload cannot serve
    if (INHIBIT_CYC < 1 || READ_DELAY_CYC < 1 || READ_DELAY_CYC > INHIBIT_CYC ||
        LOAD_WAIT_CYC <= LOAD_GAP_CYC + 2 || INHIBIT_CYC >= (1 << 24) ||
        LOAD_WAIT_CYC >= (1 << 24))
    begin
        $error("eeprom_host: wait counts out of range");
    end

    state_t st_ff, nxt_st;
    logic [23:0] wait_ff, nxt_wait;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] dout_ff, nxt_dout;
    logic dq_oe_n_ff, nxt_dq_oe_n;
    logic ce_n_ff, nxt_ce_n;
    logic oe_n_ff, nxt_oe_n;
    logic we_n_ff, nxt_we_n;
    logic ready_ff, nxt_ready;
    logic rd_valid_ff, nxt_rd_valid;
    logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
    logic busy_ff, nxt_busy;
    logic read_ok_ff, nxt_read_ok;
    logic [DATA_W-1:0] last_data_ff, nxt_last_data;
    logic [ADDR_W-1:0] last_addr_ff, nxt_last_addr;
    logic [DATA_W-1:0] dq_meta_ff, dq_sync_ff;
    logic tim_busy_ff, nxt_tim_busy;
    strobe_if tim ();

    wait_timer u_timer (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .req(tim)
    );

    // data pins come from the device's own timing, so synchronise them
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dq_meta_ff <= DATA_RST;
            dq_sync_ff <= DATA_RST;
        end
        else
        begin
            dq_meta_ff <= dq_i;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    // sequencer: strobes change only on register edges, so no glitches
    always_comb
    begin
        nxt_st = st_ff;
        nxt_wait = wait_ff;
        nxt_addr = addr_ff;
        nxt_dout = dout_ff;
        nxt_dq_oe_n = dq_oe_n_ff;
        nxt_ce_n = ce_n_ff;
        nxt_oe_n = oe_n_ff;
        nxt_we_n = we_n_ff;
        nxt_ready = 1'b0;
        nxt_rd_valid = 1'b0;
        nxt_rd_data = rd_data_ff;
        nxt_busy = busy_ff;
        nxt_read_ok = read_ok_ff;
        nxt_last_data = last_data_ff;
        nxt_last_addr = last_addr_ff;
        nxt_tim_busy = tim_busy_ff;
        tim.start = 1'b0;
        tim.cycles = 12'h000;
        case (st_ff)
            ST_POWERUP:
            begin
                // read delay flagged after short wait; reads and writes both wait for full inhibit
                if (wait_ff != 24'h00_0000)
                begin
                    nxt_wait = wait_ff - 24'h00_0001;
                end
                if (wait_ff <= 24'(INHIBIT_CYC - READ_DELAY_CYC))
                begin
                    nxt_read_ok = 1'b1;
                end
                // both the read delay and the write inhibit must have run out
                if (wait_ff == 24'h00_0000 && read_ok_ff)
                begin
                    nxt_st = ST_IDLE;
                    nxt_ready = 1'b1;
                end
            end
            ST_IDLE:
            begin
                nxt_ready = 1'b1;
                if (req_i && ready_ff)
                begin
                    nxt_ready = 1'b0;
                    nxt_addr = req_addr_i;
                    nxt_ce_n = 1'b0;
                    tim.start = 1'b1;
                    if (req_write_i)
                    begin
                        // output enable high before write goes low
                        nxt_oe_n = 1'b1;
                        nxt_we_n = 1'b0;
                        nxt_dout = req_data_i;
                        nxt_dq_oe_n = 1'b0;
                        nxt_last_data = req_data_i;
                        nxt_last_addr = req_addr_i;
                        nxt_busy = 1'b1;
                        tim.cycles = 12'(STROBE_LOW_CYC);
                        nxt_tim_busy = req_last_i;
                        nxt_st = ST_WR_LOW;
                    end
                    else
                    begin
                        nxt_oe_n = 1'b0;
                        nxt_dq_oe_n = 1'b1;
                        tim.cycles = 12'(READ_ACC_CYC);
                        nxt_st = ST_RD;
                    end
                end
            end
            ST_RD:
            begin
                if (tim.done)
                begin
                    nxt_rd_data = dq_sync_ff;
                    nxt_rd_valid = 1'b1;
                    nxt_ce_n = 1'b1;
                    nxt_oe_n = 1'b1;
                    nxt_st = ST_IDLE;
                end
            end
            ST_WR_LOW:
            begin
                if (tim.done)
                begin
                    // data held through rising edge, then released next phase
                    nxt_we_n = 1'b1;
                    nxt_ce_n = 1'b1;
                    tim.start = 1'b1;
                    tim.cycles = 12'(LOAD_GAP_CYC);
                    nxt_st = ST_WR_GAP;
                end
            end
            ST_WR_GAP:
            begin
                nxt_dq_oe_n = 1'b1;
                if (tim.done)
                begin
                    if (tim_busy_ff)
                    begin
                        nxt_wait = 24'(LOAD_WAIT_CYC);
                        nxt_st = ST_LOAD_WAIT;
                    end
                    else
                    begin
                        // next load must come within the load interval
                        nxt_wait = 24'(LOAD_WAIT_CYC - LOAD_GAP_CYC - 2);
                        nxt_ready = 1'b1;
                        nxt_st = ST_IDLE;
                    end
                end
            end
            ST_LOAD_WAIT:
            begin
                nxt_wait = wait_ff - 24'h00_0001;
                if (wait_ff == 24'h00_0001)
                begin
                    nxt_st = ST_POLL;
                    nxt_addr = last_addr_ff;
                    nxt_ce_n = 1'b0;
                    nxt_oe_n = 1'b0;
                    tim.start = 1'b1;
                    tim.cycles = 12'(READ_ACC_CYC);
                end
            end
            ST_POLL:
            begin
                if (tim.done)
                begin
                    nxt_ce_n = 1'b1;
                    nxt_oe_n = 1'b1;
                    tim.start = 1'b1;
                    tim.cycles = 12'(LOAD_GAP_CYC);
                    // done when bit seven matches the last data written; one matching read ends the poll, no confirming read
                    if (dq_sync_ff[POLL_STATUS_BIT] == last_data_ff[POLL_STATUS_BIT])
                    begin
                        nxt_busy = 1'b0;
                        nxt_st = ST_IDLE;
                    end
                    else
                    begin
                        nxt_st = ST_POLL_GAP;
                    end
                end
            end
            ST_POLL_GAP:
            begin
                if (tim.done)
                begin
                    nxt_ce_n = 1'b0;
                    nxt_oe_n = 1'b0;
                    tim.start = 1'b1;
                    tim.cycles = 12'(READ_ACC_CYC);
                    nxt_st = ST_POLL;
                end
            end
            default:
            begin
                nxt_st = ST_IDLE;
            end
        endcase
        // a partly loaded page whose user went quiet: close it out
        if (st_ff == ST_IDLE && busy_ff && !tim_busy_ff && !(req_i && ready_ff))
        begin
            if (wait_ff != 24'h00_0000)
            begin
                nxt_wait = wait_ff - 24'h00_0001;
            end
            else
            begin
                nxt_tim_busy = 1'b1;
                nxt_wait = 24'(LOAD_WAIT_CYC);
                nxt_ready = 1'b0;
                nxt_st = ST_LOAD_WAIT;
            end
        end
        if (st_ff == ST_IDLE && nxt_st == ST_IDLE && busy_ff && req_i && ready_ff && !req_write_i)
        begin
            nxt_st = ST_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_ff <= ST_POWERUP;
            wait_ff <= 24'(INHIBIT_CYC);
            addr_ff <= ADDR_RST;
            dout_ff <= DATA_RST;
            dq_oe_n_ff <= 1'b1;
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            ready_ff <= 1'b0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= DATA_RST;
            busy_ff <= 1'b0;
            read_ok_ff <= 1'b0;
            last_data_ff <= DATA_RST;
            last_addr_ff <= ADDR_RST;
            tim_busy_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            wait_ff <= nxt_wait;
            addr_ff <= nxt_addr;
            dout_ff <= nxt_dout;
            dq_oe_n_ff <= nxt_dq_oe_n;
            ce_n_ff <= nxt_ce_n;
            oe_n_ff <= nxt_oe_n;
            we_n_ff <= nxt_we_n;
            ready_ff <= nxt_ready;
            rd_valid_ff <= nxt_rd_valid;
            rd_data_ff <= nxt_rd_data;
            busy_ff <= nxt_busy;
            read_ok_ff <= nxt_read_ok;
            last_data_ff <= nxt_last_data;
            last_addr_ff <= nxt_last_addr;
            tim_busy_ff <= nxt_tim_busy;
        end
    end

    assign ready_o = ready_ff;
    assign rd_valid_o = rd_valid_ff;
    assign rd_data_o = rd_data_ff;
    assign busy_o = busy_ff;
    assign byte_address_o = addr_ff;
    assign dq_o = dout_ff;
    assign dq_oe_n_o = dq_oe_n_ff;
    assign ce_n_o = ce_n_ff;
    assign oe_n_o = oe_n_ff;
    assign we_n_o = we_n_ff;

    // write strobe never low together with output enable low
    property p_no_write_with_oe;
        @(posedge clk_i) disable iff (!arst_n_i)
        !we_n_o |-> (oe_n_o && !ce_n_o);
    endproperty
    a_no_write_with_oe: assert property (p_no_write_with_oe)
        else $error("write strobe low while output enable low");

    // host never drives data while output enable is low
    property p_no_contention;
        @(posedge clk_i) disable iff (!arst_n_i)
        !oe_n_o |-> dq_oe_n_o;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("host drives data during read");

    // write pulse held for the full low time, never a glitch
    sequence s_we_fall;
        $fell(we_n_o);
    endsequence
    property p_we_width;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_we_fall |-> !we_n_o [*2];
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write pulse too short");

    // data stable across the rising write edge
    property p_data_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(we_n_o) |-> (!dq_oe_n_o && $stable(dq_o));
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data not held at rising edge");

    // no write during power-up inhibit
    property p_inhibit;
        @(posedge clk_i) disable iff (!arst_n_i)
        (st_ff == ST_POWERUP) |-> (we_n_o && ce_n_o);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("write attempted during power-up inhibit");

    // address stable while write strobe low
    property p_addr_stable;
        @(posedge clk_i) disable iff (!arst_n_i)
        (!we_n_o && !$past(we_n_o)) |-> $stable(byte_address_o);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved during write pulse");

    // busy never drops without a poll read
    property p_busy_clear;
        @(posedge clk_i) disable iff (!arst_n_i)
        $fell(busy_o) |-> $past(st_ff) == ST_POLL;
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("busy cleared without poll");

    // read data reported only after strobes end the read
    property p_rd_valid;
        @(posedge clk_i) disable iff (!arst_n_i)
        rd_valid_o |-> (ce_n_o && oe_n_o);
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read reported while strobes active");
endmodule

/* pkg/eeprom_host_pkg.sv */
// constants for the parallel eeprom host controller
package eeprom_host_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 128;
    localparam int OFFS_W = 7;
    // strobe low time, ns, and derived cycles (least time rounds up)
    localparam int STROBE_LOW_NS = 100;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // strobe high gap between loads, ns (byte load interval minimum)
    localparam int LOAD_GAP_NS = 100;
    localparam int LOAD_GAP_CYC = (LOAD_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // read access time, ns, plus three cycle margin for input synchroniser
    localparam int READ_ACC_NS = 150;
    localparam int READ_ACC_CYC = (READ_ACC_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + 3;
    // byte load interval maximum, us; host waits at least this after last load
    localparam int BYTE_LOAD_INTERVAL_US = 100;
    localparam int BYTE_LOAD_INTERVAL_CYC = BYTE_LOAD_INTERVAL_US * (CLK_HZ / 1_000_000);
    // power-up write inhibit maximum, ms
    localparam int POWER_UP_WRITE_INHIBIT_MS = 10;
    localparam int POWER_UP_WRITE_INHIBIT_CYC = POWER_UP_WRITE_INHIBIT_MS * (CLK_HZ / 1000);
    // power-up read delay maximum, us
    localparam int POWER_UP_READ_DELAY_US = 100;
    localparam int POWER_UP_READ_DELAY_CYC = POWER_UP_READ_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int POLL_STATUS_BIT = 7;
    localparam int ALTERNATING_STATUS_BIT = 6;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
endpackage

/* pkg/strobe_if.sv */
// request channel between host sequencer and strobe timer
`timescale 1ns/10ps
interface strobe_if;
    logic start;
    logic [11:0] cycles;
    logic done;
    modport master (output start, output cycles, input done);
    modport slave (input start, input cycles, output done);
endinterface

/* hdl/wait_timer.sv */
// one-shot down counter timing strobe phases and waits
`timescale 1ns/10ps
module wait_timer
    import eeprom_host_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    strobe_if.slave req
);
    logic [11:0] cnt_ff;
    logic [11:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;

    // done pulses one cycle after count reaches one
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        if (req.start)
        begin
            nxt_cnt = req.cycles;
        end
        else if (cnt_ff != 12'h0000)
        begin
            nxt_cnt = cnt_ff - 12'h0001;
            nxt_done = (cnt_ff == 12'h0001);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_ff <= 12'h0000;
            done_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign req.done = done_ff;
endmodule

/* tb/eeprom_model.sv */
// behavioural byte-wide eeprom answering the host controller's pins
`timescale 1ns/10ps
module eeprom_model
#(
    parameter int ACC_NS = 150,
    parameter int BLC_NS = 800,
    parameter int WC_NS = 20000,
    parameter int INHIBIT_NS = 2000,
    parameter int PUR_NS = 100,
    parameter int GLITCH_NS = 20
)
(
    input wire logic [15:0] byte_address_i,
    input wire logic [7:0] dq_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    output logic [7:0] dq_o,
    output logic drive_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] page_buf [0:127];
    logic [127:0] loaded = '0;
    logic [8:0] page = '0;
    logic [15:0] load_addr = '0;
    logic [7:0] last_data = '0;
    logic busy = 1'b0;
    logic toggle = 1'b0;
    logic rd_late = 1'b0;
    logic pending = 1'b0;
    realtime wr_fall = 0;
    realtime wr_rise = 0;
    wire wr_act = !ce_n_i && !we_n_i && oe_n_i;
    wire rd_act = !ce_n_i && !oe_n_i && we_n_i;

    // erased array at power-up
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hff;
    end

    // address taken when the later strobe falls
    always @(posedge wr_act)
    begin
        wr_fall = $realtime;
        load_addr = byte_address_i;
    end

    // data taken when the earlier strobe rises; short pulses and early writes dropped
    always @(negedge wr_act)
    begin
        if ($realtime - wr_fall >= GLITCH_NS && $realtime >= INHIBIT_NS && !busy)
        begin
            page = load_addr[15:7];
            page_buf[load_addr[6:0]] = dq_i;
            loaded[load_addr[6:0]] = 1'b1;
            last_data = dq_i;
            pending = 1'b1;
        end
        wr_rise = $realtime;
    end

    // coarse-step load timer; a strobe held low keeps it from expiring
    always #10
    begin
        if (pending && !wr_act && $realtime - wr_rise >= BLC_NS)
        begin
            pending = 1'b0;
            busy = 1'b1;
            #(WC_NS);
            for (int i = 0; i < 128; i++)
                if (loaded[i]) mem[{page, i[6:0]}] = page_buf[i];
            loaded = '0;
            busy = 1'b0;
        end
    end

    // slow answer: output only after the access time has run
    always @(rd_act) rd_late <= #(ACC_NS) rd_act;
    always @(posedge rd_act) toggle = ~toggle;

    // status pattern while busy, stored data otherwise
    always @*
    begin
        drive_o = rd_act && rd_late && ($realtime >= PUR_NS);
        if (busy)
            dq_o = {~last_data[7], toggle, ~last_data[5:0]};
        else
            dq_o = mem[byte_address_i];
    end
endmodule

/* tb/parallel_eeprom_rw_page_write_tb.sv */
// self-checking bench: eeprom host controller against the device model
`timescale 1ns/10ps
`define CHECK_EQ(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module parallel_eeprom_rw_page_write_tb;
    import eeprom_host_pkg::*;
    localparam int INH = 50;
    localparam int LW = 20;
    localparam int LIMIT = 20000;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic req_last_i = 1'b0;
    logic [ADDR_W-1:0] req_addr_i = 16'h0000;
    logic [DATA_W-1:0] req_data_i = 8'h00;
    logic ready_o, rd_valid_o, busy_o, dq_oe_n_o, ce_n_o, oe_n_o, we_n_o, mdl_drv;
    logic [DATA_W-1:0] rd_data_o, dq_o, mdl_dq, rd;
    logic [DATA_W-1:0] bus_w = 8'h5a;
    logic [ADDR_W-1:0] byte_address_o;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    always #25 clk_i = ~clk_i;

    // wire level: host, then device, else a floating line that keeps flipping
    always @(dq_oe_n_o, dq_o, mdl_drv, mdl_dq)
    begin
        if (!dq_oe_n_o) bus_w = dq_o;
        else if (mdl_drv) bus_w = mdl_dq;
        else bus_w = ~bus_w;
    end

    eeprom_host #(.INHIBIT_CYC(INH), .READ_DELAY_CYC(10), .LOAD_WAIT_CYC(LW)) DUT (
        .clk_i, .arst_n_i, .req_i, .req_write_i, .req_last_i, .req_addr_i, .req_data_i,
        .ready_o, .rd_valid_o, .rd_data_o, .busy_o, .byte_address_o, .dq_o, .dq_oe_n_o,
        .dq_i(bus_w), .ce_n_o, .oe_n_o, .we_n_o);

    eeprom_model MDL (.byte_address_i(byte_address_o), .dq_i(bus_w), .ce_n_i(ce_n_o),
        .oe_n_i(oe_n_o), .we_n_i(we_n_o), .dq_o(mdl_dq), .drive_o(mdl_drv));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // a hung handshake ends the run as a mismatch
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            give_verdict();
        end
    end

    task automatic issue(input logic wr, input logic last, input logic [15:0] a,
                         input logic [7:0] d);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 1000)
        begin
            @(negedge clk_i);
            n++;
        end
        req_i = 1'b1;
        req_write_i = wr;
        req_last_i = last;
        req_addr_i = a;
        req_data_i = d;
        @(negedge clk_i);
        req_i = 1'b0;
    endtask

    task automatic read_byte(input logic [15:0] a);
        int n;
        n = 0;
        issue(1'b0, 1'b0, a, 8'h00);
        while (rd_valid_o !== 1'b1 && n < 40)
        begin
            @(negedge clk_i);
            n++;
        end
        rd = rd_data_o;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 3000)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask

    // strobes parked in reset, no request taken before the inhibit has run
    task automatic t_power_up();
        int n;
        n = 0;
        `CHECK_EQ({ce_n_o, oe_n_o, we_n_o, dq_oe_n_o, ready_o}, 5'b11110)
        arst_n_i = 1'b1;
        while (ready_o !== 1'b1 && n < 200)
        begin
            @(negedge clk_i);
            n++;
        end
        `CHECK_EQ(n >= INH, 1'b1)
        read_byte(16'h0040);
        `CHECK_EQ(rd, 8'hff)
        $display("power_up done");
    endtask

    task automatic t_byte_write();
        issue(1'b1, 1'b1, 16'h1234, 8'h5a);
        `CHECK_EQ(busy_o, 1'b1)
        wait_idle();
        read_byte(16'h1234);
        `CHECK_EQ(rd, 8'h5a)
        read_byte(16'h1235);
        `CHECK_EQ(rd, 8'hff)
        $display("byte_write done");
    endtask

    // loads back to back, offsets out of order, one offset left unloaded
    task automatic t_page_write();
        issue(1'b1, 1'b0, 16'h037f, 8'h11);
        issue(1'b1, 1'b0, 16'h0305, 8'h22);
        issue(1'b1, 1'b1, 16'h0300, 8'h33);
        wait_idle();
        read_byte(16'h037f);
        `CHECK_EQ(rd, 8'h11)
        read_byte(16'h0305);
        `CHECK_EQ(rd, 8'h22)
        read_byte(16'h0300);
        `CHECK_EQ(rd, 8'h33)
        read_byte(16'h0301);
        `CHECK_EQ(rd, 8'hff)
        $display("page_write done");
    endtask

    // lone load without last mark: controller closes the page itself, then
    // keeps busy through inverted-bit polls for the whole programming time
    task automatic t_poll_busy();
        int n;
        n = 0;
        issue(1'b1, 1'b0, 16'h2000, 8'h80);
        repeat (LW + 20) @(negedge clk_i);
        `CHECK_EQ({busy_o, ready_o}, 2'b10)
        while (busy_o === 1'b1 && n < 3000)
        begin
            @(negedge clk_i);
            n++;
        end
        `CHECK_EQ(n > 300, 1'b1)
        read_byte(16'h2000);
        `CHECK_EQ(rd, 8'h80)
        $display("poll_busy done");
    endtask

    // reset in mid-write drops every strobe at once
    task automatic t_midrun_reset();
        issue(1'b1, 1'b1, 16'h4000, 8'h01);
        arst_n_i = 1'b0;
        @(negedge clk_i);
        `CHECK_EQ({ce_n_o, oe_n_o, we_n_o, dq_oe_n_o, busy_o}, 5'b11110)
        arst_n_i = 1'b1;
        repeat (INH - 2) @(negedge clk_i);
        `CHECK_EQ(ready_o, 1'b0)
        $display("midrun_reset done");
    endtask

    initial
    begin
        repeat (8) @(negedge clk_i);
        t_power_up();
        t_byte_write();
        t_page_write();
        t_poll_busy();
        t_midrun_reset();
        give_verdict();
    end
endmodule
